/* File: core/wss_engine.sv */
// Contract
// R1 - Each state is one 32-bit instruction, fixed or decision
// R2 - Data bus driven/tristated or sampled per state
// R3 - Fixed state holds control outputs whole state
// R4 - Fixed state lasts programmed cycle count
// R5 - All seven fixed: S6 falls to idle
// R6 - Idle waits for firmware trigger
// R7 - Fewer states: idle only by explicit branch
// R8 - Decision combines two sampled signals, then branches
// R9 - Control task runs once on state entry
// R10 - Self-loop with re-execute repeats task
// R11 - No re-execute: task once, keep sampling
// R12 - Terms: six readies, FIFO flag, internal, count
// R13 - Logic function is AND, OR or XOR
// R14 - Single signal: select it twice with AND
// R15 - Separate targets for result one and zero
// R16 - Decision spends at least one cycle
// R17 - Transitions only on rising clock edge
// R18 - Seven states S0-S6 plus idle S7
// R19 - Branch to idle ends the waveform
// R20 - Duration zero means 256 cycles
// R21 - After reset rest idle until trigger
module wss_engine
  import wss_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [5:0]  READY_IN,
  input  wire logic        TXN_EXPIRED,
  input  wire logic [2:0]  FIFO_FLAGS,
  input  wire logic [7:0]  FD_IN,
  output logic      [7:0]  FD_OUT,
  output logic             FD_OE,
  output logic      [5:0]  CTL_OUT,
  output logic      [5:0]  CTL_OE,
  output logic      [8:0]  ADDR_OUT,
  output logic             FIFO_ADVANCE,
  output logic             DONE
);
  function automatic wss_ctl_type ctl_decode(input logic [7:0] b,
                                             input logic       tri_mode);
    wss_ctl_type c;
    if (tri_mode) begin
      c.value = {2'b00, b[3:0]};
      c.oe    = {2'b00, b[WSS_OE_LO +: 4]};
    end else begin
      c.value = b[5:0];
      c.oe    = WSS_CTL_ALL;
    end
    return c;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'b00) &&
           ((a <= WSS_OFF_INSTR_E && a != WSS_OFF_INSTR_E) ||
            (a >= WSS_OFF_CTRL && a <= WSS_OFF_ADDR));
  endfunction

  // Instruction memory and software registers
  logic          [31:0] mem_q [WSS_NSTATES];
  logic          [31:0] mem_d [WSS_NSTATES];
  logic          [15:0] ctrl_q, ctrl_d;
  logic          [7:0]  wdata_q, wdata_d;
  logic          [31:0] prdata_q, prdata_d;
  logic                 pready_q, pready_d;
  logic                 pslverr_q, pslverr_d;
  // Sequencer state
  wss_seq_type          seq_q, seq_d;
  logic          [2:0]  cur_q, cur_d;
  logic          [8:0]  cnt_q, cnt_d;
  logic                 entry_q, entry_d;
  wss_terms_type        terms_q, terms_d;
  logic          [8:0]  addr_q, addr_d;
  logic          [7:0]  rdata_q, rdata_d;
  wss_ctl_type          ctl_q, ctl_d;
  logic                 fd_oe_q, fd_oe_d;
  logic                 adv_q, adv_d;
  logic                 done_q, done_d;
  // Helpers
  wss_instr_type        cur_i;
  wss_instr_type        nxt_i;
  logic                 apb_setup;
  logic                 apb_wr;
  logic                 idle;
  logic                 run;
  logic                 trig;
  logic                 dp;
  logic                 reexec;
  logic                 res;
  logic          [8:0]  dur;
  logic          [2:0]  tgt;
  logic                 go_next;

  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr    = PSEL & PENABLE & PWRITE & pready_q;
  assign idle      = (seq_q == WSS_SEQ_IDLE);
  assign run       = (seq_q == WSS_SEQ_RUN);
  assign trig      = apb_wr && idle && PADDR == WSS_OFF_CTRL &&
                     PWDATA[WSS_CTRL_TRIG]; // R6
  assign cur_i     = run ? wss_instr_type'(mem_q[cur_q]) : '0; // R1
  assign dp        = cur_i.opcode[WSS_OP_DP]; // R1
  assign reexec    = cur_i.len_br[WSS_BR_REEXEC];
  assign dur       = (cur_i.len_br == 8'h00) ? WSS_LEN_MAX
                                            : {1'b0, cur_i.len_br}; // R20

  wss_decide u_decide (
    .logic_fn (cur_i.logic_fn),
    .terms    (terms_q),
    .result   (res)
  );

  // Register file over the bus; zero-wait answers
  always_comb begin
    mem_d     = mem_q;
    ctrl_d    = ctrl_q;
    wdata_d   = wdata_q;
    prdata_d  = prdata_q;
    pready_d  = apb_setup;
    pslverr_d = apb_setup && !addr_ok(PADDR);
    if (apb_setup) begin
      prdata_d = '0;
      if (PADDR < WSS_OFF_INSTR_E && PADDR[1:0] == 2'b00) begin
        prdata_d = mem_q[PADDR[4:2]];
      end else begin
        case (PADDR)
          WSS_OFF_CTRL:   prdata_d[15:0] = ctrl_q;
          WSS_OFF_STATUS: begin
            prdata_d[WSS_ST_DONE]       = done_q;
            prdata_d[WSS_ST_STATE +: 3] = cur_q;
            prdata_d[WSS_ST_ADDR +: 9]  = addr_q;
          end
          WSS_OFF_WDATA:  prdata_d[7:0] = wdata_q;
          WSS_OFF_RDATA:  prdata_d[7:0] = rdata_q;
          WSS_OFF_ADDR:   prdata_d[8:0] = addr_q;
          default:        prdata_d = '0;
        endcase
      end
    end
    // Writes are refused while a waveform runs
    if (apb_wr && idle) begin
      if (PADDR < WSS_OFF_INSTR_E && PADDR[1:0] == 2'b00) begin
        mem_d[PADDR[4:2]] = PWDATA;
      end else if (PADDR == WSS_OFF_CTRL) begin
        ctrl_d = PWDATA[15:0];
        ctrl_d[WSS_CTRL_TRIG] = 1'b0;
      end else if (PADDR == WSS_OFF_WDATA) begin
        wdata_d = PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < WSS_NSTATES; i++) begin
        mem_q[i] <= '0;
      end
      ctrl_q    <= WSS_CTRL_RST;
      wdata_q   <= '0;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      mem_q     <= mem_d;
      ctrl_q    <= ctrl_d;
      wdata_q   <= wdata_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Waveform sequencer
  always_comb begin
    seq_d   = seq_q;
    cur_d   = cur_q;
    cnt_d   = cnt_q + WSS_ONE9;
    entry_d = 1'b0;
    go_next = 1'b0;
    tgt     = cur_q + 3'h1;
    addr_d  = addr_q;
    rdata_d = rdata_q;
    nxt_i   = '0;
    terms_d.rdy        = READY_IN; // R8
    terms_d.tce        = TXN_EXPIRED;
    // Setup written with the trigger applies from the first state
    terms_d.tce_sel    = ctrl_d[WSS_CTRL_TCE];
    terms_d.fifo_flags = FIFO_FLAGS;
    terms_d.flag_sel   = ctrl_d[WSS_CTRL_FSEL +: 2];
    terms_d.int_rdy    = ctrl_d[WSS_CTRL_INTERNAL_READY_BIT];
    unique case (seq_q)
      WSS_SEQ_IDLE: begin
        cnt_d = '0;
        if (trig) begin // R6
          seq_d   = WSS_SEQ_RUN;
          cur_d   = WSS_FIRST_IDX; // R18
          entry_d = 1'b1;
        end
        if (apb_wr && PADDR == WSS_OFF_ADDR) begin
          addr_d = PWDATA[8:0];
        end
      end
      WSS_SEQ_RUN: begin
        if (dp) begin // R16
          go_next = 1'b1;
          tgt = res ? cur_i.len_br[WSS_BR1_LO +: 3]
                    : cur_i.len_br[WSS_BR0_LO +: 3]; // R15
        end else if (cnt_q == dur - WSS_ONE9) begin // R4
          go_next = 1'b1;
          if (cur_q == WSS_LAST_IDX) begin
            tgt = WSS_IDLE_IDX; // R5 R7
          end
        end
        if (run && entry_q && !FD_OE && ctrl_q[WSS_CTRL_READ] &&
            cur_i.opcode[WSS_OP_DATA]) begin
          rdata_d = FD_IN; // R2
        end
        if (go_next) begin
          cnt_d = '0;
          if (tgt == WSS_IDLE_IDX) begin
            seq_d = WSS_SEQ_IDLE; // R19
            cur_d = WSS_IDLE_IDX;
          end else begin
            cur_d   = tgt; // R17
            entry_d = (tgt != cur_q) || reexec; // R9 R10 R11
          end
        end
      end
    endcase
    if (seq_d == WSS_SEQ_RUN) begin
      nxt_i = mem_q[cur_d];
    end
    if (entry_d && nxt_i.opcode[WSS_OP_INCAD]) begin
      addr_d = addr_q + WSS_ONE9; // R9
    end
    adv_d = entry_d && nxt_i.opcode[WSS_OP_NEXT] &&
            !ctrl_d[WSS_CTRL_READ]; // R9
    if (seq_d == WSS_SEQ_RUN) begin
      ctl_d   = ctl_decode(nxt_i.ctl, ctrl_d[WSS_CTRL_TRICTL]); // R3
      fd_oe_d = !ctrl_d[WSS_CTRL_READ] &&
                nxt_i.opcode[WSS_OP_DATA]; // R2
    end else begin
      ctl_d   = ctl_decode(ctrl_d[WSS_CTRL_IDLE +: 8],
                           ctrl_d[WSS_CTRL_TRICTL]);
      fd_oe_d = ctrl_d[WSS_CTRL_IDRV];
    end
    done_d = (seq_d == WSS_SEQ_IDLE);
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      seq_q   <= WSS_SEQ_IDLE; // R21
      cur_q   <= WSS_IDLE_IDX;
      cnt_q   <= '0;
      entry_q <= 1'b0;
      terms_q <= '0;
      addr_q  <= '0;
      rdata_q <= '0;
      ctl_q   <= '0;
      fd_oe_q <= 1'b0;
      adv_q   <= 1'b0;
      done_q  <= 1'b1;
    end else begin
      seq_q   <= seq_d;
      cur_q   <= cur_d;
      cnt_q   <= cnt_d;
      entry_q <= entry_d;
      terms_q <= terms_d;
      addr_q  <= addr_d;
      rdata_q <= rdata_d;
      ctl_q   <= ctl_d;
      fd_oe_q <= fd_oe_d;
      adv_q   <= adv_d;
      done_q  <= done_d;
    end
  end

  assign PRDATA       = prdata_q;
  assign PREADY       = pready_q;
  assign PSLVERR      = pslverr_q;
  assign FD_OUT       = wdata_q;
  assign FD_OE        = fd_oe_q;
  assign CTL_OUT      = ctl_q.value;
  assign CTL_OE       = ctl_q.oe;
  assign ADDR_OUT     = addr_q;
  assign FIFO_ADVANCE = adv_q;
  assign DONE         = done_q;

  a_idle_after_reset: assert property ( // R21
    @(posedge SYS_CLK) SYS_RST |=> (idle && DONE && !FD_OE))
    else $error("not idle after reset");

  a_trigger_start: assert property ( // R6
    @(posedge SYS_CLK) disable iff (SYS_RST)
    trig |=> (run && cur_q == WSS_FIRST_IDX && entry_q && !DONE))
    else $error("trigger did not start S0");

  a_idle_waits: assert property ( // R6
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (idle && !trig) |=> (idle && DONE))
    else $error("left idle without trigger");

  a_ndp_holds: assert property ( // R4
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (run && !dp && cnt_q != dur - WSS_ONE9)
    |=> (cur_q == $past(cur_q) && !entry_q))
    else $error("fixed state left early");

  a_ndp_advance: assert property ( // R4
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (run && !dp && cnt_q == dur - WSS_ONE9 && cur_q != WSS_LAST_IDX)
    |=> (run && cur_q == $past(cur_q) + 3'h1 && cnt_q == 9'h000))
    else $error("fixed state did not advance");

  a_last_to_idle: assert property ( // R5
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (run && !dp && cur_q == WSS_LAST_IDX && cnt_q == dur - WSS_ONE9)
    |=> (idle && DONE))
    else $error("S6 did not fall to idle");

  a_dp_branch: assert property ( // R15
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (run && dp && tgt != WSS_IDLE_IDX) |=> (run && cur_q == $past(tgt)))
    else $error("decision branch wrong");

  a_dp_to_idle: assert property ( // R19
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (run && dp && tgt == WSS_IDLE_IDX) |=> ##[0:0] (idle && DONE))
    else $error("branch to idle did not end waveform");

  a_reexec_task: assert property ( // R10
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (run && dp && tgt == cur_q && reexec) |=> entry_q)
    else $error("re-execute missed");

  a_no_reexec: assert property ( // R11
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (run && dp && tgt == cur_q && !reexec) |=> (!entry_q && !FIFO_ADVANCE))
    else $error("task repeated without re-execute");

  a_ctl_hold: assert property ( // R3
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (run && $past(run) && cur_q == $past(cur_q)) |-> $stable(CTL_OUT))
    else $error("control output moved inside state");

  a_fd_drive: assert property ( // R2
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (run && !ctrl_q[WSS_CTRL_READ]) |-> (FD_OE == cur_i.opcode[WSS_OP_DATA]))
    else $error("data bus drive mismatch");

  a_addr_step: assert property ( // R9
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (run && !entry_q && $past(run)) |-> $stable(ADDR_OUT))
    else $error("address moved without state entry");
endmodule

/* File: common/wss_pkg.sv */
package wss_pkg;
  localparam int          WSS_NSTATES   = 7;
  localparam logic [2:0]  WSS_FIRST_IDX = 3'h0;
  localparam logic [2:0]  WSS_LAST_IDX  = 3'h6;
  localparam logic [2:0]  WSS_IDLE_IDX  = 3'h7;
  localparam logic [8:0]  WSS_LEN_MAX   = 9'h100;
  localparam logic [8:0]  WSS_ONE9      = 9'h001;
  localparam logic [5:0]  WSS_CTL_ALL   = 6'h3f;

  // Register byte offsets
  localparam logic [7:0]  WSS_OFF_INSTR0  = 8'h00;
  localparam logic [7:0]  WSS_OFF_INSTR_E = 8'h1c;
  localparam logic [7:0]  WSS_OFF_CTRL    = 8'h20;
  localparam logic [7:0]  WSS_OFF_STATUS  = 8'h24;
  localparam logic [7:0]  WSS_OFF_WDATA   = 8'h28;
  localparam logic [7:0]  WSS_OFF_RDATA   = 8'h2c;
  localparam logic [7:0]  WSS_OFF_ADDR    = 8'h30;
  localparam logic [15:0] WSS_CTRL_RST    = 16'h0000;

  // Control register fields
  localparam int WSS_CTRL_TRIG   = 0;
  localparam int WSS_CTRL_READ   = 1;
  localparam int WSS_CTRL_TRICTL = 2;
  localparam int WSS_CTRL_TCE    = 3;
  localparam int WSS_CTRL_INTERNAL_READY_BIT = 4;
  localparam int WSS_CTRL_FSEL   = 5;
  localparam int WSS_CTRL_IDRV   = 7;
  localparam int WSS_CTRL_IDLE   = 8;

  // Status register fields
  localparam int WSS_ST_DONE  = 0;
  localparam int WSS_ST_STATE = 1;
  localparam int WSS_ST_ADDR  = 4;

  // Instruction byte fields
  localparam int WSS_OP_DP     = 0;
  localparam int WSS_OP_DATA   = 1;
  localparam int WSS_OP_NEXT   = 2;
  localparam int WSS_OP_INCAD  = 3;
  localparam int WSS_BR_REEXEC = 7;
  localparam int WSS_BR1_LO    = 3;
  localparam int WSS_BR0_LO    = 0;
  localparam int WSS_LF_LO     = 6;
  localparam int WSS_TA_LO     = 3;
  localparam int WSS_TB_LO     = 0;
  localparam int WSS_OE_LO     = 4;

  localparam logic [1:0] WSS_LF_AND = 2'h0;
  localparam logic [1:0] WSS_LF_OR  = 2'h1;
  localparam logic [1:0] WSS_LF_XOR = 2'h2;

  localparam logic [2:0] WSS_TERM_READY_IN_5   = 3'h5;
  localparam logic [2:0] WSS_TERM_FIFO   = 3'h6;
  localparam logic [2:0] WSS_TERM_INTERNAL_READY_BIT = 3'h7;

  localparam logic [1:0] WSS_FSEL_PROG  = 2'h0;
  localparam logic [1:0] WSS_FSEL_EMPTY = 2'h1;

  typedef struct packed {
    logic [7:0] len_br;
    logic [7:0] opcode;
    logic [7:0] logic_fn;
    logic [7:0] ctl;
  } wss_instr_type;

  typedef struct packed {
    logic [5:0] rdy;
    logic       tce;
    logic       tce_sel;
    logic [2:0] fifo_flags;
    logic [1:0] flag_sel;
    logic       int_rdy;
  } wss_terms_type;

  typedef struct packed {
    logic [5:0] value;
    logic [5:0] oe;
  } wss_ctl_type;

  typedef enum logic [1:0] {
    WSS_SEQ_IDLE = 2'b01,
    WSS_SEQ_RUN  = 2'b10
  } wss_seq_type;
endpackage

/* File: core/wss_decide.sv */
module wss_decide
  import wss_pkg::*;
(
  input  wire logic [7:0]    logic_fn,
  input  wire wss_terms_type terms,
  output logic               result
);
  function automatic logic term_pick(input logic [2:0]    sel,
                                     input wss_terms_type t);
    logic f;
    f = 1'b0;
    case (sel)
      WSS_TERM_READY_IN_5: begin
        f = t.tce_sel ? t.tce : t.rdy[5];
      end
      WSS_TERM_FIFO: begin
        if (t.flag_sel == WSS_FSEL_PROG) begin
          f = t.fifo_flags[0];
        end else if (t.flag_sel == WSS_FSEL_EMPTY) begin
          f = t.fifo_flags[1];
        end else begin
          f = t.fifo_flags[2];
        end
      end
      WSS_TERM_INTERNAL_READY_BIT: f = t.int_rdy;
      default:         f = t.rdy[sel];
    endcase
    return f;
  endfunction

  logic term_a;
  logic term_b;

  always_comb begin
    term_a = term_pick(logic_fn[WSS_TA_LO +: 3], terms); // R12
    term_b = term_pick(logic_fn[WSS_TB_LO +: 3], terms); // R12
    case (logic_fn[WSS_LF_LO +: 2]) // R13
      WSS_LF_OR:  result = term_a | term_b;
      WSS_LF_XOR: result = term_a ^ term_b;
      default:    result = term_a & term_b;
    endcase
  end
endmodule

/* File: test/wss_periph.sv */
module wss_periph (
  input  wire logic       clk,
  input  wire logic [7:0] fd_out,
  input  wire logic       fd_oe,
  input  wire logic [7:0] drive_val,
  input  wire logic [5:0] rdy_val,
  output logic      [5:0] rdy,
  output logic      [7:0] fd_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial rdy = 6'h00;

  // Ready lines answer one edge after they are requested
  always @(posedge clk) begin
    rdy <= rdy_val;
  end

  // Bus level: device data while it drives, own data otherwise
  assign fd_in = (fd_oe === 1'b1) ? fd_out : drive_val;
endmodule

/* File: test/tb.sv */
module tb
  import wss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic        psel       = 1'b0;
  logic        pen        = 1'b0;
  logic        pwr        = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  rdy_val    = 6'h00;
  logic [5:0]  rdy;
  logic        txn        = 1'b0;
  logic [2:0]  flags      = 3'h0;
  logic [7:0]  drv        = 8'h00;
  logic [7:0]  fd_in;
  logic [7:0]  fd_out;
  logic        fd_oe;
  logic [5:0]  ctl_out;
  logic [5:0]  ctl_oe;
  logic [8:0]  addr_out;
  logic        done;
  logic        adv;
  logic [31:0] cfg        = 32'h0;
  int          mismatches = 0;
  int          compares   = 0;
  // Function, term A, term B, expected result
  logic [8:0]  tbl [8]    = '{9'b00_001_111_1, 9'b00_001_000_0,
                              9'b01_000_101_0, 9'b01_110_111_1,
                              9'b10_001_111_0, 9'b10_110_001_1,
                              9'b11_111_110_0, 9'b11_111_111_1};

  always #2.5 clk = ~clk;

  wss_engine wss_engine_inst (
    .SYS_CLK      (clk),
    .SYS_RST      (rst),
    .PSEL         (psel),
    .PENABLE      (pen),
    .PWRITE       (pwr),
    .PADDR        (paddr),
    .PWDATA       (pwdata),
    .PRDATA       (prdata),
    .PREADY       (pready),
    .PSLVERR      (pslverr),
    .READY_IN     (rdy),
    .TXN_EXPIRED  (txn),
    .FIFO_FLAGS   (flags),
    .FD_IN        (fd_in),
    .FD_OUT       (fd_out),
    .FD_OE        (fd_oe),
    .CTL_OUT      (ctl_out),
    .CTL_OE       (ctl_oe),
    .ADDR_OUT     (addr_out),
    .FIFO_ADVANCE (adv),
    .DONE         (done)
  );

  wss_periph wss_periph_inst (
    .clk       (clk),
    .fd_out    (fd_out),
    .fd_oe     (fd_oe),
    .drive_val (drv),
    .rdy_val   (rdy_val),
    .rdy       (rdy),
    .fd_in     (fd_in)
  );

  task automatic complete_run;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic bail;
    mismatches++;
    complete_run;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= wr_en;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    // Look mid-cycle, then let the edge that samples ready pass
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bail;
    r = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  // Trigger with the current setup, count busy cycles, drop ready late
  task automatic go(input logic [5:0] r, input int hold, output int n);
    rdy_val <= r;
    wr(WSS_OFF_CTRL, cfg | 32'h1);
    n = 0;
    while (n < 400) begin
      @(negedge clk);
      if (done === 1'b1) break;
      n++;
      if (n == hold) rdy_val <= 6'h00;
    end
    if (n >= 400) bail;
  endtask

  task automatic after_reset;
    logic [31:0] r;
    logic        e;
    check(32'(done), 32'h1);
    apb(1'b0, WSS_OFF_STATUS, 32'h0, r, e);
    check(32'(r[3:1]), 32'h7);
    apb(1'b0, 8'hfc, 32'h0, r, e);
    check(32'(e), 32'h1);
  endtask

  task automatic fixed_run;
    int s;
    int c;
    cfg = 32'h0;
    wr(WSS_OFF_CTRL, cfg);
    wr(WSS_OFF_WDATA, 32'h5a);
    for (s = 0; s < 7; s++)
      wr(8'(4 * s), {8'(s + 1), 5'h0, s[0], s[0], 1'b0, 8'h00,
                     8'(s * 9 + 3)});
    wr(WSS_OFF_CTRL, 32'h1);
    for (s = 0; s < 7; s++)
      for (c = 0; c <= s; c++) begin
        @(negedge clk);
        check(32'({ctl_oe, ctl_out}), 32'({6'h3f, 6'(s * 9 + 3)}));
        check(32'({done, fd_oe}), 32'({1'b0, s[0]}));
        check(32'(adv), 32'(s[0] && c == 0));
        if (s[0]) check(32'(fd_out), 32'h5a);
      end
    @(negedge clk);
    check(32'(done), 32'h1);
  endtask

  task automatic long_read;
    int          n;
    int          s;
    logic [31:0] r;
    logic        e;
    cfg = 32'h2;
    drv <= 8'hc3;
    for (s = 1; s < 7; s++)
      wr(8'(4 * s), 32'h0100_0000);
    wr(WSS_OFF_INSTR0, 32'h0002_0000);
    go(6'h00, 0, n);
    check(32'(n), 32'd262);
    apb(1'b0, WSS_OFF_RDATA, 32'h0, r, e);
    check(32'(r[7:0]), 32'hc3);
  endtask

  task automatic decide_loop;
    int         n;
    int         rx;
    int         h;
    logic [8:0] a0;
    cfg = 32'h0;
    for (rx = 0; rx < 2; rx++)
      for (h = 0; h < 6; h += 5) begin
        // Wait on ready_in_0 alone: same term twice, AND
        wr(WSS_OFF_INSTR0, {rx[0], 4'h0, 3'h7, 24'h09_00_00});
        a0 = addr_out;
        go(6'(h > 0), h, n);
        check(32'(addr_out - a0), rx ? n : 1);
        check(32'(h ? (n > 5) : n), 32'h1);
      end
  endtask

  task automatic logic_table;
    int         n;
    int         k;
    logic [8:0] a0;
    cfg = 32'h38;
    flags <= 3'h5;
    txn <= 1'b0;
    wr(8'h04, 32'h3f09_0000);
    for (k = 0; k < 8; k++) begin
      wr(WSS_OFF_INSTR0, {8'h0f, 8'h01, tbl[k][8:1], 8'h00});
      a0 = addr_out;
      go(6'h22, 0, n);
      check(32'(addr_out - a0), 32'(tbl[k][0]));
      check(32'(n), 32'(tbl[k][0]) + 32'h1);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    after_reset;
    fixed_run;
    long_read;
    decide_loop;
    logic_table;
    complete_run;
  end
endmodule
